// ===== common/flash_ctrl_pkg.sv
// constants, types and register map of the on-chip flash controller
// assumes one 125 MHz clock and a plain strobe register port
package flash_ctrl_pkg;

  // ***************************************
  // clock and timing
  // ***************************************
  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned NS_PER_US     = 1000;
  // clocks per microsecond after reset, derived from the clock period
  localparam logic [7:0]  USEC_RST      = 8'(NS_PER_US / CLK_PERIOD_NS);
  // pulse lengths in microseconds; cycles = figure * clocks per microsecond
  localparam logic [15:0] PROG_TIME_US  = 16'h0014;
  localparam logic [15:0] ERASE_TIME_US = 16'h0064;

  // ***************************************
  // array geometry
  // ***************************************
  localparam int unsigned BADDR_W   = 12;               // byte address
  localparam int unsigned WIDX_W    = BADDR_W - 2;      // word index
  localparam int unsigned NUM_WORDS = 1 << WIDX_W;
  localparam int unsigned BLK_W     = 10;               // 1 kB erase unit
  localparam int unsigned BLKNUM_W  = BADDR_W - BLK_W;
  localparam int unsigned REGION_W  = BADDR_W - 11;     // 2 kB region
  localparam int unsigned REGIONS   = 1 << REGION_W;
  localparam logic [31:0] ERASED_WORD = 32'hffff_ffff;

  // ***************************************
  // register offsets
  // ***************************************
  localparam logic [7:0] OFS_ADDR = 8'h00;
  localparam logic [7:0] OFS_DATA = 8'h04;
  localparam logic [7:0] OFS_CMD  = 8'h08;  // write command, read status
  localparam logic [7:0] OFS_USEC = 8'h0c;
  localparam logic [7:0] OFS_RIS  = 8'h10;
  localparam logic [7:0] OFS_IM   = 8'h14;
  localparam logic [7:0] OFS_MIS  = 8'h18;
  localparam logic [7:0] OFS_ICLR = 8'h1c;
  localparam logic [7:0] OFS_PROT = 8'h20;
  localparam logic [7:0] OFS_CMIT = 8'h24;  // committed settings, read only

  // ***************************************
  // field positions and reset values
  // ***************************************
  localparam int unsigned CMD_PROG_BIT    = 0;
  localparam int unsigned CMD_ERASE_BIT   = 1;
  localparam int unsigned CMD_COMMIT_BIT  = 2;
  localparam int unsigned ST_BUSY_BIT     = 0;
  localparam int unsigned ST_ERR_BIT      = 1;
  localparam int unsigned INT_DONE_BIT    = 0;
  localparam int unsigned INT_ACCESS_BIT  = 1;
  localparam int unsigned PROT_REGION_BIT = 8;
  localparam logic [1:0]  IM_RST          = 2'h0;

  typedef enum logic [1:0] {
    PROT_RW = 2'b00,
    PROT_RO = 2'b01,
    PROT_XO = 2'b10
  } prot_t;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_PROG  = 2'b01,
    ST_ERASE = 2'b10
  } state_t;

  // one-cycle order to the array
  typedef struct packed {
    logic              prog;
    logic              erase;
    logic [WIDX_W-1:0] widx;
    logic [31:0]       data;
  } arr_op_t;

endpackage : flash_ctrl_pkg

// ===== design/flash_array.sv
// word-wide flash storage with block erase and clear-only program
// assumes orders come one cycle long from the controller
`timescale 1ns/100ps
`default_nettype none

module flash_array (
  input  wire logic                                clk,
  input  wire logic                                por,
  input  wire flash_ctrl_pkg::arr_op_t             op,
  input  wire logic                                rd_en,
  input  wire logic [flash_ctrl_pkg::WIDX_W-1:0]   rd_widx,
  output var  logic [31:0]                         rdata
);

  logic [31:0] mem_q [flash_ctrl_pkg::NUM_WORDS];
  logic [31:0] rdata_d;
  logic [31:0] rdata_q;

  // ***************************************
  // storage
  // ***************************************
  for (genvar i = 0; i < flash_ctrl_pkg::NUM_WORDS; i++) begin : g_word
    localparam logic [flash_ctrl_pkg::WIDX_W-1:0] IDX = flash_ctrl_pkg::WIDX_W'(i);
    logic [31:0] word_d;
    // erase sets the whole unit to ones, program only clears bits
    always_comb begin
      word_d = mem_q[i];
      if (op.erase && (op.widx[flash_ctrl_pkg::WIDX_W-1 -: flash_ctrl_pkg::BLKNUM_W] ==
                       IDX[flash_ctrl_pkg::WIDX_W-1 -: flash_ctrl_pkg::BLKNUM_W])) begin
        word_d = flash_ctrl_pkg::ERASED_WORD;
      end else if (op.prog && (op.widx == IDX)) begin
        word_d = mem_q[i] & op.data;  // a one leaves the bit as is
      end
    end
    // contents survive the ordinary reset; power-on starts erased
    always_ff @(posedge clk) begin
      if (por) begin
        mem_q[i] <= flash_ctrl_pkg::ERASED_WORD;
      end else begin
        mem_q[i] <= word_d;
      end
    end
  end

  // ***************************************
  // read port
  // ***************************************
  // denied reads return zero rather than stale data
  always_comb begin
    rdata_d = rd_en ? mem_q[rd_widx] : 32'h0000_0000;
  end

  always_ff @(posedge clk) begin
    if (por) begin
      rdata_q <= 32'h0000_0000;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign rdata = rdata_q;

endmodule : flash_array

`default_nettype wire

// ===== design/flash_ctrl.sv
// on-chip flash controller: command sequencer, protection, interrupt flags
// assumes synchronous strobes on the register and array ports, POR on power-up
//
// What this block does
// - array is split into 1 kB units, each erased alone by one command
// - erase leaves every bit of the unit at one
// - one protection setting per 2 kB region
// - read-only regions refuse erase and program
// - execute-only regions refuse erase as well
// - execute-only regions serve fetches only, deny data and debug reads
// - program works on one word and only clears bits
// - repeated programs on a word between erases are accepted
// - pulses are timed in microseconds from the clocks-per-microsecond value
// - forbidden accesses set the access flag
// - finished erase or program sets the completion flag
// - protection acts at once; commit is a separate irreversible step
// - erase to an invalid or protected unit fails, reports error, array untouched
// - clear request drops exactly the selected flags, except one raised in the same cycle
// - each flag has an enable; only enabled flags reach the interrupt line
// - raw and masked flags are both readable
// - protection may only tighten; loosening is rejected
// - uncommitted protection lasts until reset, then committed settings return
`timescale 1ns/100ps
`default_nettype none

module flash_ctrl (
  input  wire logic                                 REF_CLK,
  input  wire logic                                 SRST,
  input  wire logic                                 POR,
  input  wire logic [7:0]                           REG_ADDR,
  input  wire logic [31:0]                          REG_WDATA,
  input  wire logic                                 REG_WR,
  input  wire logic                                 REG_RD,
  output var  logic [31:0]                          REG_RDATA,
  input  wire logic [flash_ctrl_pkg::BADDR_W-1:0]   MEM_ADDR,
  input  wire logic                                 MEM_FETCH,
  input  wire logic                                 MEM_READ,
  input  wire logic                                 MEM_DBG_READ,
  output var  logic [31:0]                          MEM_RDATA,
  output var  logic                                 MEM_DENY,
  output var  logic                                 BUSY,
  output var  logic                                 INTR
);

  // ***************************************
  // helpers
  // ***************************************
  function automatic logic reg_hit(input logic [7:0] ofs);
    return REG_WR && (REG_ADDR == ofs);
  endfunction : reg_hit

  function automatic logic [flash_ctrl_pkg::REGION_W-1:0] region_of(
      input logic [flash_ctrl_pkg::BADDR_W-1:0] a);
    return a[flash_ctrl_pkg::BADDR_W-1 -: flash_ctrl_pkg::REGION_W];
  endfunction : region_of

  // a new setting is legal if equal or stricter than the old one
  function automatic logic may_set(input flash_ctrl_pkg::prot_t old_p,
                                   input logic [1:0] new_p);
    logic ok;
    ok = (new_p == old_p) ||
         ((old_p == flash_ctrl_pkg::PROT_RW) && (new_p != 2'b11)) ||
         ((old_p == flash_ctrl_pkg::PROT_RO) && (new_p == flash_ctrl_pkg::PROT_XO));
    return ok;
  endfunction : may_set

  // ***************************************
  // state
  // ***************************************
  flash_ctrl_pkg::state_t                        state_d, state_q;
  logic [15:0]                                   cnt_d, cnt_q;
  logic [7:0]                                    pre_d, pre_q;
  logic [7:0]                                    usec_d, usec_q;
  logic [31:0]                                   addr_d, addr_q;
  logic [31:0]                                   data_d, data_q;
  logic [flash_ctrl_pkg::WIDX_W-1:0]             owidx_d, owidx_q;
  logic [31:0]                                   odata_d, odata_q;
  logic                                          err_d, err_q;
  logic [1:0]                                    ris_d, ris_q;
  logic [1:0]                                    im_d, im_q;
  flash_ctrl_pkg::prot_t [flash_ctrl_pkg::REGIONS-1:0] prot_d, prot_q;
  flash_ctrl_pkg::prot_t [flash_ctrl_pkg::REGIONS-1:0] cmit_d, cmit_q;
  logic [flash_ctrl_pkg::REGION_W-1:0]           sel_d, sel_q;
  flash_ctrl_pkg::arr_op_t                       op_d;
  logic                                          deny_d, deny_q;
  logic [31:0]                                   rdata_d, rdata_q;

  logic [7:0]                                    usec_m1;
  logic                                          tick;
  logic                                          xo_read;
  logic                                          rd_en;
  logic [1:0]                                    clr;
  logic [1:0]                                    set;
  logic [1:0]                                    new_p;
  logic [flash_ctrl_pkg::REGION_W-1:0]           new_r;
  logic                                          tgt_prot;
  logic                                          out_rng;

  // ***************************************
  // sequencer, protection and flags
  // ***************************************
  // a zero clocks-per-microsecond value is treated as one
  assign usec_m1  = (usec_q == 8'h00) ? 8'h00 : usec_q - 8'h01;
  assign tick     = (pre_q >= usec_m1);
  assign xo_read  = (MEM_READ || MEM_DBG_READ) && !MEM_FETCH &&
                    (prot_q[region_of(MEM_ADDR)] == flash_ctrl_pkg::PROT_XO);
  assign out_rng  = (addr_q[31:flash_ctrl_pkg::BADDR_W] != '0);
  assign tgt_prot = (prot_q[region_of(addr_q[flash_ctrl_pkg::BADDR_W-1:0])] !=
                     flash_ctrl_pkg::PROT_RW);
  assign new_p    = REG_WDATA[1:0];
  assign new_r    = REG_WDATA[flash_ctrl_pkg::PROT_REGION_BIT +: flash_ctrl_pkg::REGION_W];

  // next values of all control state
  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    pre_d   = pre_q;
    usec_d  = usec_q;
    addr_d  = addr_q;
    data_d  = data_q;
    owidx_d = owidx_q;
    odata_d = odata_q;
    err_d   = err_q;
    im_d    = im_q;
    prot_d  = prot_q;
    cmit_d  = cmit_q;
    sel_d   = sel_q;
    op_d    = '0;
    set     = 2'b00;
    clr     = reg_hit(flash_ctrl_pkg::OFS_ICLR) ? REG_WDATA[1:0] : 2'b00;
    if (xo_read) begin
      set[flash_ctrl_pkg::INT_ACCESS_BIT] = 1'b1;
    end
    if (reg_hit(flash_ctrl_pkg::OFS_IM)) begin
      im_d = REG_WDATA[1:0];
    end
    // operands are frozen while busy so the running pulse cannot be retargeted
    if (state_q == flash_ctrl_pkg::ST_IDLE) begin
      if (reg_hit(flash_ctrl_pkg::OFS_ADDR)) begin
        addr_d = REG_WDATA;
      end
      if (reg_hit(flash_ctrl_pkg::OFS_DATA)) begin
        data_d = REG_WDATA;
      end
      if (reg_hit(flash_ctrl_pkg::OFS_USEC)) begin
        usec_d = REG_WDATA[7:0];
      end
    end
    // protection setting acts at once and only tightens
    if (reg_hit(flash_ctrl_pkg::OFS_PROT)) begin
      sel_d = new_r;
      if (may_set(prot_q[new_r], new_p)) begin
        prot_d[new_r] = flash_ctrl_pkg::prot_t'(new_p);
      end else begin
        err_d = 1'b1;
      end
    end
    if (reg_hit(flash_ctrl_pkg::OFS_CMD) && REG_WDATA[flash_ctrl_pkg::CMD_COMMIT_BIT]) begin
      cmit_d = prot_q;  // irreversible: cleared only at power-on
    end
    case (state_q)
      flash_ctrl_pkg::ST_IDLE: begin
        pre_d = 8'h00;
        if (reg_hit(flash_ctrl_pkg::OFS_CMD) && REG_WDATA[flash_ctrl_pkg::CMD_PROG_BIT]) begin
          if (out_rng) begin
            err_d = 1'b1;
          end else if (tgt_prot) begin
            err_d = 1'b1;
            set[flash_ctrl_pkg::INT_ACCESS_BIT] = 1'b1;
          end else begin
            state_d = flash_ctrl_pkg::ST_PROG;
            cnt_d   = flash_ctrl_pkg::PROG_TIME_US;
            err_d   = 1'b0;
            // low address bits dropped: word alignment is the caller's job
            owidx_d = addr_q[flash_ctrl_pkg::BADDR_W-1:2];
            odata_d = data_q;
          end
        end else if (reg_hit(flash_ctrl_pkg::OFS_CMD) &&
                     REG_WDATA[flash_ctrl_pkg::CMD_ERASE_BIT]) begin
          if (out_rng || (addr_q[flash_ctrl_pkg::BLK_W-1:0] != '0)) begin
            err_d = 1'b1;
          end else if (tgt_prot) begin
            err_d = 1'b1;
            set[flash_ctrl_pkg::INT_ACCESS_BIT] = 1'b1;
          end else begin
            state_d = flash_ctrl_pkg::ST_ERASE;
            cnt_d   = flash_ctrl_pkg::ERASE_TIME_US;
            err_d   = 1'b0;
            owidx_d = addr_q[flash_ctrl_pkg::BADDR_W-1:2];
          end
        end
      end
      flash_ctrl_pkg::ST_PROG, flash_ctrl_pkg::ST_ERASE: begin
        // prescaler makes one tick per microsecond
        pre_d = tick ? 8'h00 : pre_q + 8'h01;
        if (tick) begin
          if (cnt_q <= 16'h0001) begin
            op_d.prog  = (state_q == flash_ctrl_pkg::ST_PROG);
            op_d.erase = (state_q == flash_ctrl_pkg::ST_ERASE);
            op_d.widx  = owidx_q;
            op_d.data  = odata_q;
            set[flash_ctrl_pkg::INT_DONE_BIT] = 1'b1;
            state_d = flash_ctrl_pkg::ST_IDLE;
          end else begin
            cnt_d = cnt_q - 16'h0001;
          end
        end
      end
      default: begin
        state_d = flash_ctrl_pkg::ST_IDLE;
      end
    endcase
    // a flag raised in the cycle of its clear stays set
    ris_d = (ris_q & ~clr) | set;
  end

  // ordinary reset restores committed protection, power-on restores all
  always_ff @(posedge REF_CLK) begin
    if (POR) begin
      cmit_q <= '{default: flash_ctrl_pkg::PROT_RW};
    end else begin
      cmit_q <= cmit_d;
    end
    if (POR) begin
      prot_q <= '{default: flash_ctrl_pkg::PROT_RW};
    end else if (SRST) begin
      prot_q <= cmit_q;
    end else begin
      prot_q <= prot_d;
    end
    if (SRST || POR) begin
      state_q <= flash_ctrl_pkg::ST_IDLE;
      cnt_q   <= 16'h0000;
      pre_q   <= 8'h00;
      usec_q  <= flash_ctrl_pkg::USEC_RST;
      addr_q  <= 32'h0000_0000;
      data_q  <= flash_ctrl_pkg::ERASED_WORD;
      owidx_q <= '0;
      odata_q <= flash_ctrl_pkg::ERASED_WORD;
      err_q   <= 1'b0;
      ris_q   <= 2'b00;
      im_q    <= flash_ctrl_pkg::IM_RST;
      sel_q   <= '0;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      pre_q   <= pre_d;
      usec_q  <= usec_d;
      addr_q  <= addr_d;
      data_q  <= data_d;
      owidx_q <= owidx_d;
      odata_q <= odata_d;
      err_q   <= err_d;
      ris_q   <= ris_d;
      im_q    <= im_d;
      sel_q   <= sel_d;
    end
  end

  // ***************************************
  // register read path
  // ***************************************
  // unmapped offsets and idle cycles read as zero
  always_comb begin
    rdata_d = 32'h0000_0000;
    if (!REG_RD) begin
      rdata_d = 32'h0000_0000;
    end else if (REG_ADDR == flash_ctrl_pkg::OFS_ADDR) begin
      rdata_d = addr_q;
    end else if (REG_ADDR == flash_ctrl_pkg::OFS_DATA) begin
      rdata_d = data_q;
    end else if (REG_ADDR == flash_ctrl_pkg::OFS_CMD) begin
      rdata_d[flash_ctrl_pkg::ST_BUSY_BIT] = (state_q != flash_ctrl_pkg::ST_IDLE);
      rdata_d[flash_ctrl_pkg::ST_ERR_BIT]  = err_q;
    end else if (REG_ADDR == flash_ctrl_pkg::OFS_USEC) begin
      rdata_d[7:0] = usec_q;
    end else if (REG_ADDR == flash_ctrl_pkg::OFS_RIS) begin
      rdata_d[1:0] = ris_q;
    end else if (REG_ADDR == flash_ctrl_pkg::OFS_IM) begin
      rdata_d[1:0] = im_q;
    end else if (REG_ADDR == flash_ctrl_pkg::OFS_MIS) begin
      rdata_d[1:0] = ris_q & im_q;
    end else if (REG_ADDR == flash_ctrl_pkg::OFS_PROT) begin
      rdata_d[1:0] = prot_q[sel_q];
      rdata_d[flash_ctrl_pkg::PROT_REGION_BIT +: flash_ctrl_pkg::REGION_W] = sel_q;
    end else if (REG_ADDR == flash_ctrl_pkg::OFS_CMIT) begin
      rdata_d[1:0] = cmit_q[sel_q];
      rdata_d[flash_ctrl_pkg::PROT_REGION_BIT +: flash_ctrl_pkg::REGION_W] = sel_q;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (SRST || POR) begin
      rdata_q <= 32'h0000_0000;
      deny_q  <= 1'b0;
    end else begin
      rdata_q <= rdata_d;
      deny_q  <= deny_d;
    end
  end

  // ***************************************
  // array access
  // ***************************************
  // data reads of execute-only regions are blocked before the array
  assign deny_d = xo_read;
  assign rd_en  = (MEM_FETCH || MEM_READ || MEM_DBG_READ) && !xo_read;

  flash_array u_array (
    .clk     (REF_CLK),
    .por     (POR),
    .op      (op_d),
    .rd_en   (rd_en),
    .rd_widx (MEM_ADDR[flash_ctrl_pkg::BADDR_W-1:2]),
    .rdata   (MEM_RDATA)
  );

  assign REG_RDATA = rdata_q;
  assign MEM_DENY  = deny_q;
  assign BUSY      = (state_q != flash_ctrl_pkg::ST_IDLE);
  assign INTR      = |(ris_q & im_q);

endmodule : flash_ctrl

`default_nettype wire

// ===== sim/core_model.sv
// processor core and debugger stand-in: register and array master
// assumes a free running clock; tasks are called from the testbench
`timescale 1ns/100ps
`default_nettype none
module core_model (
  input  wire logic                                clk,
  output var  logic [7:0]                          reg_addr,
  output var  logic [31:0]                         reg_wdata,
  output var  logic                                reg_wr,
  output var  logic                                reg_rd,
  input  wire logic [31:0]                         reg_rdata,
  output var  logic [flash_ctrl_pkg::BADDR_W-1:0]  mem_addr,
  output var  logic                                mem_fetch,
  output var  logic                                mem_read,
  output var  logic                                mem_dbg_read,
  input  wire logic [31:0]                         mem_rdata,
  input  wire logic                                mem_deny
);
  // everything quiet at time zero
  initial begin
    {reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
    {mem_addr, mem_fetch, mem_read, mem_dbg_read} = '0;
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd
  // kind 0 fetch, 1 core read, 2 debugger read
  task automatic mrd(input logic [1:0] k, input logic [11:0] a, output logic [31:0] d,
                     output logic dn);
    @(posedge clk);
    mem_addr     <= {a[11:2], 2'b00};
    mem_fetch    <= (k == 2'h0);
    mem_read     <= (k == 2'h1);
    mem_dbg_read <= (k == 2'h2);
    @(posedge clk);
    {mem_fetch, mem_read, mem_dbg_read} <= 3'h0;
    #1 d = mem_rdata;
    dn = mem_deny;
  endtask : mrd
endmodule : core_model
`default_nettype wire

// ===== sim/flash_ctrl_chk.sv
// port assertions for the flash controller
// assumes one clock domain; bound onto flash_ctrl
`timescale 1ns/100ps
`default_nettype none
module flash_ctrl_chk (
  input wire logic        REF_CLK,
  input wire logic        SRST,
  input wire logic        POR,
  input wire logic [7:0]  REG_ADDR,
  input wire logic [31:0] REG_WDATA,
  input wire logic        REG_WR,
  input wire logic        REG_RD,
  input wire logic [31:0] REG_RDATA,
  input wire logic        MEM_FETCH,
  input wire logic        MEM_READ,
  input wire logic        MEM_DBG_READ,
  input wire logic [31:0] MEM_RDATA,
  input wire logic        MEM_DENY,
  input wire logic        BUSY,
  input wire logic        INTR
);
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (SRST || POR);
  logic [15:0] bcnt_q;
  logic [15:0] bcnt_d;
  // busy length, saturating so a slow erase never wraps
  always_comb begin
    bcnt_d = !BUSY ? 16'h0 : (&bcnt_q ? bcnt_q : bcnt_q + 16'h1);
  end
  always_ff @(posedge REF_CLK) begin
    bcnt_q <= (SRST || POR) ? 16'h0 : bcnt_d;
  end
  sequence s_mask_off;
    REG_WR && REG_ADDR == flash_ctrl_pkg::OFS_IM && REG_WDATA[1:0] == 2'h0;
  endsequence
  a_deny_needs_read:
    assert property (MEM_DENY |-> $past(MEM_READ || MEM_DBG_READ) && !$past(MEM_FETCH))
    else $error("deny without a data read");
  a_deny_zero_data:
    assert property (MEM_DENY |-> MEM_RDATA == 32'h0) else $error("denied read leaks data");
  a_fetch_served:
    assert property (MEM_FETCH |=> !MEM_DENY) else $error("fetch denied");
  a_rdata_idle:
    assert property (!REG_RD |=> REG_RDATA == 32'h0) else $error("read data without strobe");
  a_status_busy:
    assert property (REG_RD && REG_ADDR == flash_ctrl_pkg::OFS_CMD
      |=> REG_RDATA[0] == $past(BUSY)) else $error("status busy bit wrong");
  a_busy_from_cmd:
    assert property ($rose(BUSY) |-> $past(REG_WR && REG_ADDR == flash_ctrl_pkg::OFS_CMD))
    else $error("busy without command");
  a_busy_min_len:
    assert property ($fell(BUSY) && !$past(SRST || POR) |-> bcnt_q >= flash_ctrl_pkg::PROG_TIME_US)
    else $error("pulse shorter than program time");
  a_intr_masked:
    assert property (s_mask_off |=> !INTR) else $error("masked flag drives line");
endmodule : flash_ctrl_chk
bind flash_ctrl flash_ctrl_chk u_chk (.*);
`default_nettype wire

// ===== sim/test_onchip_flash_controller.sv
// self-checking bench for the flash controller
// assumes core_model as master and the checker bound onto the design
`timescale 1ns/100ps
`default_nettype none
module test_onchip_flash_controller;
  logic        clk, srst, por, reg_wr, reg_rd, busy, intr;
  logic        mem_fetch, mem_read, mem_dbg_read, mem_deny;
  logic [7:0]  reg_addr;
  logic [11:0] mem_addr;
  logic [31:0] reg_wdata, reg_rdata, mem_rdata;
  int          mismatches;
  int          comparisons;
  flash_ctrl u_dut (.REF_CLK(clk), .SRST(srst), .POR(por), .REG_ADDR(reg_addr),
    .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata),
    .MEM_ADDR(mem_addr), .MEM_FETCH(mem_fetch), .MEM_READ(mem_read),
    .MEM_DBG_READ(mem_dbg_read), .MEM_RDATA(mem_rdata), .MEM_DENY(mem_deny),
    .BUSY(busy), .INTR(intr));
  core_model u_core (.*);
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      $display("[FAIL] %s expected %h seen %h", n, e, g);
      mismatches++;
    end
  endtask : chk
  task automatic rc(input string n, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    u_core.rd(a, d);
    chk(n, e, d);
  endtask : rc
  task automatic mc(input string n, input logic [1:0] k, input logic [11:0] a,
                    input logic [31:0] e, input logic ed);
    logic [31:0] d;
    logic        dn;
    u_core.mrd(k, a, d, dn);
    chk(n, e, d);
    chk("deny", {31'h0, ed}, {31'h0, dn});
  endtask : mc
  // bounded wait: erase at one clock per microsecond is far shorter
  task automatic idle();
    #1;
    for (int i = 0; i < 3000 && busy !== 1'b0; i++) begin
      @(posedge clk);
      #1;
    end
    chk("busy", 32'h0, {31'h0, busy});
  endtask : idle
  task automatic op(input logic [31:0] a, input logic [31:0] d, input logic [31:0] c);
    u_core.wr(flash_ctrl_pkg::OFS_ADDR, a);
    u_core.wr(flash_ctrl_pkg::OFS_DATA, d);
    u_core.wr(flash_ctrl_pkg::OFS_CMD, c);
    idle();
  endtask : op
  task automatic pulse_reset();
    @(posedge clk);
    srst <= 1'b1;
    @(posedge clk);
    srst <= 1'b0;
  endtask : pulse_reset
  task automatic t_regs();
    rc("usec", flash_ctrl_pkg::OFS_USEC, {24'h0, flash_ctrl_pkg::USEC_RST});
    rc("im", flash_ctrl_pkg::OFS_IM, 32'h0);
    rc("unmapped", 8'h30, 32'h0);
    u_core.wr(flash_ctrl_pkg::OFS_USEC, 32'h1);
    rc("usec set", flash_ctrl_pkg::OFS_USEC, 32'h1);
    $display("t_regs done");
  endtask : t_regs
  task automatic t_prog();
    u_core.wr(flash_ctrl_pkg::OFS_ADDR, 32'h4);
    u_core.wr(flash_ctrl_pkg::OFS_DATA, 32'ha5a5_0f0f);
    u_core.wr(flash_ctrl_pkg::OFS_CMD, 32'h1);
    u_core.wr(flash_ctrl_pkg::OFS_CMD, 32'h2);
    rc("busy bit", flash_ctrl_pkg::OFS_CMD, 32'h1);
    idle();
    mc("prog", 2'h1, 12'h004, 32'ha5a5_0f0f, 1'b0);
    op(32'h4, 32'h0000_ffff, 32'h1);
    mc("reprog", 2'h1, 12'h004, 32'h0000_0f0f, 1'b0);
    rc("done flag", flash_ctrl_pkg::OFS_RIS, 32'h1);
    u_core.wr(flash_ctrl_pkg::OFS_ICLR, 32'h1);
    rc("cleared", flash_ctrl_pkg::OFS_RIS, 32'h0);
    op(32'h404, 32'h1234_5678, 32'h1);
    $display("t_prog done");
  endtask : t_prog
  task automatic t_erase();
    op(32'h0, 32'h0, 32'h2);
    mc("erased", 2'h1, 12'h004, 32'hffff_ffff, 1'b0);
    mc("other unit", 2'h1, 12'h404, 32'h1234_5678, 1'b0);
    op(32'h404, 32'h0, 32'h2);
    rc("bad erase", flash_ctrl_pkg::OFS_CMD, 32'h2);
    mc("kept", 2'h1, 12'h404, 32'h1234_5678, 1'b0);
    $display("t_erase done");
  endtask : t_erase
  task automatic t_prot();
    u_core.wr(flash_ctrl_pkg::OFS_ICLR, 32'h3);
    u_core.wr(flash_ctrl_pkg::OFS_PROT, 32'h101);
    op(32'h800, 32'h0, 32'h1);
    rc("ro prog", flash_ctrl_pkg::OFS_CMD, 32'h2);
    rc("ro flag", flash_ctrl_pkg::OFS_RIS, 32'h2);
    mc("ro read", 2'h1, 12'h800, 32'hffff_ffff, 1'b0);
    u_core.wr(flash_ctrl_pkg::OFS_PROT, 32'h102);
    op(32'h800, 32'h0, 32'h2);
    rc("xo erase", flash_ctrl_pkg::OFS_CMD, 32'h2);
    mc("xo fetch", 2'h0, 12'h800, 32'hffff_ffff, 1'b0);
    u_core.wr(flash_ctrl_pkg::OFS_ICLR, 32'h3);
    mc("xo read", 2'h1, 12'h804, 32'h0, 1'b1);
    rc("xo flag", flash_ctrl_pkg::OFS_RIS, 32'h2);
    mc("xo debug", 2'h2, 12'h800, 32'h0, 1'b1);
    op(32'h8, 32'h0, 32'h1);
    rc("rw region", flash_ctrl_pkg::OFS_CMD, 32'h0);
    u_core.wr(flash_ctrl_pkg::OFS_PROT, 32'h100);
    rc("loosen", flash_ctrl_pkg::OFS_CMD, 32'h2);
    rc("prot kept", flash_ctrl_pkg::OFS_PROT, 32'h102);
    $display("t_prot done");
  endtask : t_prot
  task automatic t_intr();
    u_core.wr(flash_ctrl_pkg::OFS_ICLR, 32'h3);
    mc("deny", 2'h1, 12'h800, 32'h0, 1'b1);
    chk("intr off", 32'h0, {31'h0, intr});
    u_core.wr(flash_ctrl_pkg::OFS_IM, 32'h2);
    rc("mis", flash_ctrl_pkg::OFS_MIS, 32'h2);
    chk("intr on", 32'h1, {31'h0, intr});
    u_core.wr(flash_ctrl_pkg::OFS_IM, 32'h0);
    u_core.wr(flash_ctrl_pkg::OFS_IM, 32'h1);
    rc("mis none", flash_ctrl_pkg::OFS_MIS, 32'h0);
    rc("ris", flash_ctrl_pkg::OFS_RIS, 32'h2);
    u_core.wr(flash_ctrl_pkg::OFS_ICLR, 32'h2);
    rc("ris clr", flash_ctrl_pkg::OFS_RIS, 32'h0);
    $display("t_intr done");
  endtask : t_intr
  task automatic t_commit();
    pulse_reset();
    u_core.wr(flash_ctrl_pkg::OFS_PROT, 32'h100);
    rc("after reset", flash_ctrl_pkg::OFS_PROT, 32'h100);
    u_core.wr(flash_ctrl_pkg::OFS_PROT, 32'h101);
    u_core.wr(flash_ctrl_pkg::OFS_CMD, 32'h4);
    pulse_reset();
    u_core.wr(flash_ctrl_pkg::OFS_PROT, 32'h100);
    rc("committed", flash_ctrl_pkg::OFS_CMIT, 32'h101);
    rc("prot held", flash_ctrl_pkg::OFS_PROT, 32'h101);
    $display("t_commit done");
  endtask : t_commit
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : wrap_up
  // free running clock, 125 MHz
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // hang guard, far beyond the expected run
  initial begin
    #200000;
    mismatches++;
    wrap_up();
  end
  // power-on then reset release, then the scenarios
  initial begin
    srst = 1'b1;
    por  = 1'b1;
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    por  <= 1'b0;
    t_regs();
    t_prog();
    t_erase();
    t_prot();
    t_intr();
    t_commit();
    wrap_up();
  end
endmodule : test_onchip_flash_controller
`default_nettype wire
